// ===== common/tkt_consts.svh
// Register offsets, field positions, reset values and timing counts of the tick timer.
`ifndef TKT_CONSTS_SVH
`define TKT_CONSTS_SVH

`define TKT_OFF_MODE      8'h00
`define TKT_OFF_STATUS    8'h04
`define TKT_OFF_CLEARING  8'h08
`define TKT_OFF_SNAPSHOT  8'h0c
`define TKT_OFF_IRQ_MASK  8'h10
`define TKT_OFF_IRQ_STAT  8'h14

`define TKT_MODE_RESET    32'h000fffff
`define TKT_LIMIT_LSB     0
`define TKT_LIMIT_W       20
`define TKT_TALLY_LSB     20
`define TKT_TALLY_W       12
`define TKT_EN_BIT        24
`define TKT_IRQEN_BIT     25
`define TKT_FLAG_BIT      0

`define TKT_PRESCALE      16
`define TKT_PRE_W         4

`define TKT_EV_REACHED    0
`define TKT_EV_TALLYWRAP  1
`define TKT_EV_W          2

`endif

// ===== common/tkt_pkg.sv
// Types shared by the tick timer design files.
package tkt_pkg;

    typedef enum logic [1:0] {
        TKT_RD_IDLE = 2'b00,
        TKT_RD_RESP = 2'b01
    } tkt_rd_state_t;

    typedef enum logic [1:0] {
        TKT_WR_IDLE = 2'b00,
        TKT_WR_RESP = 2'b01
    } tkt_wr_state_t;

endpackage : tkt_pkg

// ===== src/tkt_prescaler.sv
// Prescaler that emits one tick every PRESCALE clock cycles while not frozen.
`timescale 1ns/10ps

module tkt_prescaler #(
    parameter int PRESCALE = 16,
    parameter int PRE_W    = 4
) (
    input  wire logic SYS_CLK,    // System clock.
    input  wire logic SYS_RST,    // Asynchronous reset, active high.
    input  wire logic freeze,     // Holds the divider while high.
    output logic      tick        // One-cycle pulse at clock divided by PRESCALE.
);

    typedef struct packed {
        logic [PRE_W-1:0] count;
    } tkt_pre_state_t;

    tkt_pre_state_t state;
    tkt_pre_state_t next_state;

    // Count the divider; the tick is decoded from the count so a freeze never swallows it.
    always_comb begin
        next_state = state;
        if (!freeze) begin
            if (state.count == PRE_W'(PRESCALE - 1)) begin
                next_state.count = '0;
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    // Register the divider state.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Tick marks the last unfrozen cycle of each divider period.
    assign tick = !freeze && (state.count == PRE_W'(PRESCALE - 1));

endmodule : tkt_prescaler

// ===== src/tkt_tick_timer.sv
// Periodic interval tick timer with an AXI4-Lite register slave.
// What this block does
// - 20-bit counter, 12-bit tally, advance at clock/16.
// - Count up, wrap at limit, bump tally.
// - Limit sets flag; interrupt if enabled.
// - Limit writes never restart the counters.
// - Clearing read returns counts, clears tally, flag.
// - Tally counts intervals since last clearing read.
// - Snapshot read returns counts without side effects.
// - Enable resets low, acts only at zero.
// - Disabled counter finishes interval then holds zero.
// - Debug state freezes both counters.
// - Interval lasts limit plus one ticks.
// - Mode: limit low, enable 24, irq-enable 25.
// - Register offsets and reset values as mapped.
// - Count in 19:0, tally in 31:20.
// - Status shows flag at bit 0 only.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "tkt_consts.svh"

module tkt_tick_timer #(
    parameter int LIMIT_W = `TKT_LIMIT_W,
    parameter int TALLY_W = `TKT_TALLY_W
) (
    input  wire logic        SYS_CLK,         // 40 MHz system clock.
    input  wire logic        SYS_RST,         // Asynchronous reset, active high.
    input  wire logic        DEBUG_HALT,      // Core is in debug state.
    input  wire logic [7:0]  S_AXI_AWADDR,    // Write address.
    input  wire logic        S_AXI_AWVALID,   // Write address valid.
    output logic             S_AXI_AWREADY,   // Write address ready.
    input  wire logic [31:0] S_AXI_WDATA,     // Write data.
    input  wire logic [3:0]  S_AXI_WSTRB,     // Write byte strobes.
    input  wire logic        S_AXI_WVALID,    // Write data valid.
    output logic             S_AXI_WREADY,    // Write data ready.
    output logic [1:0]       S_AXI_BRESP,     // Write response.
    output logic             S_AXI_BVALID,    // Write response valid.
    input  wire logic        S_AXI_BREADY,    // Write response ready.
    input  wire logic [7:0]  S_AXI_ARADDR,    // Read address.
    input  wire logic        S_AXI_ARVALID,   // Read address valid.
    output logic             S_AXI_ARREADY,   // Read address ready.
    output logic [31:0]      S_AXI_RDATA,     // Read data.
    output logic [1:0]       S_AXI_RRESP,     // Read response.
    output logic             S_AXI_RVALID,    // Read data valid.
    input  wire logic        S_AXI_RREADY,    // Read data ready.
    output logic             TICK_IRQ,        // Tick interrupt, level high.
    output logic             EVENT_IRQ        // Masked event interrupt, level high.
);

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    typedef struct packed {
        logic [LIMIT_W-1:0]    limit;
        logic                  en_req;
        logic                  irq_en;
        logic                  en_active;
        logic [LIMIT_W-1:0]    counter;
        logic [TALLY_W-1:0]    tally;
        logic                  flag;
        logic [`TKT_EV_W-1:0]  ev_stat;
        logic [`TKT_EV_W-1:0]  ev_mask;
        tkt_pkg::tkt_wr_state_t wr_state;
        logic                  aw_held;
        logic                  w_held;
        logic [7:0]            aw_addr;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic [1:0]            bresp;
        tkt_pkg::tkt_rd_state_t rd_state;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  tick_irq;
        logic                  event_irq;
    } tkt_state_t;

    tkt_state_t state;
    tkt_state_t next_state;
    logic       tick;

    // ------------------------------------------------------------------
    // Clock divider
    // ------------------------------------------------------------------

    // Divider frozen with the counters during debug.
    tkt_prescaler #(
        .PRESCALE (`TKT_PRESCALE),
        .PRE_W    (`TKT_PRE_W)
    ) u_prescaler (
        .SYS_CLK (SYS_CLK),
        .SYS_RST (SYS_RST),
        .freeze  (DEBUG_HALT),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    logic                 step;
    logic                 reached;
    logic                 clr_read;
    logic                 do_write;
    logic [31:0]          wmask;
    logic [31:0]          mode_img;
    logic [31:0]          count_img;
    logic [`TKT_EV_W-1:0] ev_set;

    // Counter, register and bus behaviour in one pass.
    always_comb begin
        next_state = state;
        mode_img   = 32'h0;
        mode_img[LIMIT_W-1:0]       = state.limit;
        mode_img[`TKT_EN_BIT]       = state.en_req;
        mode_img[`TKT_IRQEN_BIT]    = state.irq_en;
        count_img  = {state.tally, state.counter};
        wmask      = {{8{state.w_strb[3]}}, {8{state.w_strb[2]}},
                      {8{state.w_strb[1]}}, {8{state.w_strb[0]}}};

        // Tick gated counting. The divider freezes in debug.
        step     = tick && !DEBUG_HALT && state.en_active;
        reached  = step && (state.counter == state.limit);
        clr_read = 1'b0;
        do_write = 1'b0;

        if (step) begin
            if (reached) begin
                next_state.counter = '0;
            end else begin
                next_state.counter = state.counter + 1'b1;
            end
        end

        // Enable acts only at zero. Hold zero while disabled.
        if ((next_state.counter == '0) && !DEBUG_HALT) begin
            next_state.en_active = state.en_req;
        end

        // Read channel.
        case (state.rd_state)
            tkt_pkg::TKT_RD_IDLE: begin
                if (S_AXI_ARVALID) begin
                    next_state.rd_state = tkt_pkg::TKT_RD_RESP;
                    next_state.rresp    = RESP_OKAY;
                    case (S_AXI_ARADDR[7:2])
                        6'(`TKT_OFF_MODE >> 2):     next_state.rdata = mode_img;
                        6'(`TKT_OFF_STATUS >> 2):   next_state.rdata = {31'h0, state.flag};
                        6'(`TKT_OFF_CLEARING >> 2): begin
                            next_state.rdata = count_img;
                            clr_read         = 1'b1;
                        end
                        6'(`TKT_OFF_SNAPSHOT >> 2): next_state.rdata = count_img;
                        6'(`TKT_OFF_IRQ_MASK >> 2): next_state.rdata = 32'(state.ev_mask);
                        6'(`TKT_OFF_IRQ_STAT >> 2): next_state.rdata = 32'(state.ev_stat);
                        default: begin
                            next_state.rdata = 32'h0;
                            next_state.rresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            tkt_pkg::TKT_RD_RESP: begin
                if (S_AXI_RREADY) begin
                    next_state.rd_state = tkt_pkg::TKT_RD_IDLE;
                end
            end
            default: next_state.rd_state = tkt_pkg::TKT_RD_IDLE;
        endcase

        // Clearing read resets tally and flag. Increment wins.
        if (clr_read) begin
            next_state.tally = reached ? TALLY_W'(1) : '0;
            next_state.flag  = reached;
        end else if (reached) begin
            next_state.tally = state.tally + 1'b1;
            next_state.flag  = 1'b1;
        end

        // Write channel: address and data taken in either order.
        if (S_AXI_AWVALID && !state.aw_held && state.wr_state == tkt_pkg::TKT_WR_IDLE) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !state.w_held && state.wr_state == tkt_pkg::TKT_WR_IDLE) begin
            next_state.w_held = 1'b1;
            next_state.w_data = S_AXI_WDATA;
            next_state.w_strb = S_AXI_WSTRB;
        end
        ev_set = '0;
        ev_set[`TKT_EV_REACHED]   = reached;
        ev_set[`TKT_EV_TALLYWRAP] = reached && !clr_read && (state.tally == '1);
        case (state.wr_state)
            tkt_pkg::TKT_WR_IDLE: begin
                if (state.aw_held && state.w_held) begin
                    do_write            = 1'b1;
                    next_state.aw_held  = 1'b0;
                    next_state.w_held   = 1'b0;
                    next_state.wr_state = tkt_pkg::TKT_WR_RESP;
                    next_state.bresp    = RESP_OKAY;
                end
            end
            tkt_pkg::TKT_WR_RESP: begin
                if (S_AXI_BREADY) begin
                    next_state.wr_state = tkt_pkg::TKT_WR_IDLE;
                end
            end
            default: next_state.wr_state = tkt_pkg::TKT_WR_IDLE;
        endcase

        // Event status: set beats a write-one clear.
        next_state.ev_stat = state.ev_stat;
        if (do_write) begin
            case (state.aw_addr[7:2])
                6'(`TKT_OFF_MODE >> 2): begin
                    mode_img = (mode_img & ~wmask) | (state.w_data & wmask);
                    next_state.limit  = mode_img[LIMIT_W-1:0];
                    next_state.en_req = mode_img[`TKT_EN_BIT];
                    next_state.irq_en = mode_img[`TKT_IRQEN_BIT];
                end
                6'(`TKT_OFF_IRQ_MASK >> 2): begin
                    if (state.w_strb[0]) begin
                        next_state.ev_mask = state.w_data[`TKT_EV_W-1:0];
                    end
                end
                6'(`TKT_OFF_IRQ_STAT >> 2): begin
                    if (state.w_strb[0]) begin
                        next_state.ev_stat = state.ev_stat & ~state.w_data[`TKT_EV_W-1:0];
                    end
                end
                6'(`TKT_OFF_STATUS >> 2), 6'(`TKT_OFF_CLEARING >> 2),
                6'(`TKT_OFF_SNAPSHOT >> 2): begin
                    next_state.bresp = RESP_OKAY;
                end
                default: next_state.bresp = RESP_SLVERR;
            endcase
        end
        next_state.ev_stat = next_state.ev_stat | ev_set;

        next_state.tick_irq  = next_state.flag && next_state.irq_en;
        next_state.event_irq = |(next_state.ev_stat & next_state.ev_mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Register the whole block state.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state          <= '0;
            state.limit    <= LIMIT_W'(`TKT_MODE_RESET);
            state.rd_state <= tkt_pkg::TKT_RD_IDLE;
            state.wr_state <= tkt_pkg::TKT_WR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // All outputs come from state flip-flops; the ready and valid lines are decoded from the state.
    assign S_AXI_AWREADY = !state.aw_held && (state.wr_state == tkt_pkg::TKT_WR_IDLE);
    assign S_AXI_WREADY  = !state.w_held && (state.wr_state == tkt_pkg::TKT_WR_IDLE);
    assign S_AXI_BVALID  = (state.wr_state == tkt_pkg::TKT_WR_RESP);
    assign S_AXI_BRESP   = state.bresp;
    assign S_AXI_ARREADY = (state.rd_state == tkt_pkg::TKT_RD_IDLE);
    assign S_AXI_RVALID  = (state.rd_state == tkt_pkg::TKT_RD_RESP);
    assign S_AXI_RDATA   = state.rdata;
    assign S_AXI_RRESP   = state.rresp;
    assign TICK_IRQ      = state.tick_irq;
    assign EVENT_IRQ     = state.event_irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    logic [4:0] since_step;

    // Cycles since the last counter step, saturating, for the step spacing check.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            since_step <= 5'h1f;
        end else if (step) begin
            since_step <= 5'h00;
        end else if (since_step != 5'h1f) begin
            since_step <= since_step + 5'h01;
        end
    end

    sequence s_wrap;
        step && (state.counter == state.limit);
    endsequence

    property p_wrap_zero;
        @(posedge SYS_CLK) disable iff (SYS_RST) s_wrap |=> (state.counter == '0);
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap");

    property p_flag_set;
        @(posedge SYS_CLK) disable iff (SYS_RST) s_wrap |=> state.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    // Counter moves at most every sixteen cycles.
    property p_slow_step;
        @(posedge SYS_CLK) disable iff (SYS_RST)
            step |-> (since_step >= 5'h0f);
    endproperty
    a_slow_step: assert property (p_slow_step) else $error("counter stepped too fast");

    property p_debug_freeze;
        @(posedge SYS_CLK) disable iff (SYS_RST)
            (DEBUG_HALT && !clr_read) |=> $stable(state.counter) && $stable(state.tally);
    endproperty
    a_debug_freeze: assert property (p_debug_freeze) else $error("counter moved in debug");

    // Clearing read with wrap leaves tally one.
    property p_clear_race;
        @(posedge SYS_CLK) disable iff (SYS_RST)
            (clr_read && reached) |=> (state.tally == TALLY_W'(1)) && state.flag;
    endproperty
    a_clear_race: assert property (p_clear_race) else $error("interval lost on clear");

    // Clearing read alone zeroes tally and flag.
    property p_clear_read;
        @(posedge SYS_CLK) disable iff (SYS_RST)
            (clr_read && !reached) |=> (state.tally == '0) && !state.flag;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("clear read failed");

    property p_enable_at_zero;
        @(posedge SYS_CLK) disable iff (SYS_RST)
            $changed(state.en_active) |-> (state.counter == '0);
    endproperty
    a_enable_at_zero: assert property (p_enable_at_zero) else $error("enable off zero");

    property p_irq_level;
        @(posedge SYS_CLK) disable iff (SYS_RST)
            TICK_IRQ == (state.flag && state.irq_en);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("tick interrupt wrong");

endmodule : tkt_tick_timer

// ===== tb/tkt_tick_timer_test.sv
// Self-checking register-level bench for the periodic interval tick timer.
`timescale 1ns/10ps

module tkt_tick_timer_test;
    logic        sys_clk;     // Bench clock, 40 MHz.
    logic        sys_rst;     // Bench reset, active high.
    logic        halt;        // Debug state request.
    logic [7:0]  awaddr;      // Write address.
    logic        awvalid;     // Write address valid.
    logic [31:0] wdata;       // Write data.
    logic        wvalid;      // Write data valid.
    logic        bready;      // Write response ready.
    logic [7:0]  araddr;      // Read address.
    logic        arvalid;     // Read address valid.
    logic        rready;      // Read data ready.
    logic        aw_ready, w_ready, bvalid, ar_ready, rvalid, tick_irq, event_irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, v, v0;
    logic [1:0]  r;
    logic [19:0] c0;
    int          error_cnt;   // Mismatches seen.
    int          comparisons; // Comparisons made.

    tkt_tick_timer uut (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .DEBUG_HALT(halt),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TICK_IRQ(tick_irq),
        .EVENT_IRQ(event_irq)
    );

    // Free-running clock of 25 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Ends the run when a handshake wait runs out.
    task automatic bound_hit();
        error_cnt++;
        $display("BAD at %0t: got %h exp %h", $time, 1'b0, 1'b1);
        give_verdict();
    endtask : bound_hit

    // Compares one register word or response.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    // Compares one interrupt level, sampled mid-cycle.
    task automatic chk_bit(input logic exp);
        @(negedge sys_clk);
        comparisons++;
        if (tick_irq !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %h exp %h", $time, tick_irq, exp);
        end
    endtask : chk_bit

    // Compares the event interrupt level, sampled mid-cycle.
    task automatic chk_ev(input logic exp);
        @(negedge sys_clk);
        comparisons++;
        if (event_irq !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %h exp %h", $time, event_irq, exp);
        end
    endtask : chk_ev

    // One AXI4-Lite write; address and data offered together.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] er);
        logic ad, wd, ta, tw;
        int   n;
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        for (n = 0; !(ad && wd); n++) begin
            if (n > 200) bound_hit();
            @(negedge sys_clk);
            ta = awvalid && aw_ready;
            tw = wvalid && w_ready;
            @(posedge sys_clk);
            if (ta) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        for (n = 0; ; n++) begin
            @(negedge sys_clk);
            if (bvalid === 1'b1) break;
            if (n > 200) bound_hit();
        end
        chk_word({30'h0, bresp}, {30'h0, er});
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask : axi_write

    // One AXI4-Lite read returning data and response.
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] rs);
        int n;
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; ; n++) begin
            @(negedge sys_clk);
            if (ar_ready === 1'b1) break;
            if (n > 200) bound_hit();
        end
        @(posedge sys_clk);
        arvalid <= 1'b0;
        for (n = 0; ; n++) begin
            @(negedge sys_clk);
            if (rvalid === 1'b1) break;
            if (n > 200) bound_hit();
        end
        d  = rdata;
        rs = rresp;
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask : axi_read

    // Reads a register and checks data and response.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  rs;
        axi_read(a, d, rs);
        chk_word(d, ed);
        chk_word({30'h0, rs}, {30'h0, er});
    endtask : rd_chk

    // Lets the timer run for exactly n clock edges, then freezes it.
    task automatic run(input int n);
        @(posedge sys_clk);
        halt <= 1'b0;
        repeat (n) @(posedge sys_clk);
        halt <= 1'b1;
    endtask : run

    // Main sequence of tests.
    initial begin
        sys_rst = 1'b1; halt = 1'b1; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0;
        wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd_chk(8'h00, 32'h000fffff, 2'b00);
        rd_chk(8'h04, 32'h0, 2'b00);
        rd_chk(8'h08, 32'h0, 2'b00);
        rd_chk(8'h0c, 32'h0, 2'b00);
        rd_chk(8'h18, 32'h0, 2'b10);
        axi_write(8'h18, 32'hffffffff, 2'b10);
        axi_write(8'h04, 32'hffffffff, 2'b00);
        rd_chk(8'h04, 32'h0, 2'b00);
        run(200);
        rd_chk(8'h0c, 32'h0, 2'b00);
        $display("test reset_map done");
        axi_write(8'h00, 32'h03000003, 2'b00);
        rd_chk(8'h00, 32'h03000003, 2'b00);
        run(100);
        axi_read(8'h08, v0, r);
        c0 = v0[19:0];
        run(192);
        rd_chk(8'h0c, {12'h003, c0}, 2'b00);
        rd_chk(8'h04, 32'h1, 2'b00);
        chk_bit(1'b1);
        rd_chk(8'h0c, {12'h003, c0}, 2'b00);
        rd_chk(8'h08, {12'h003, c0}, 2'b00);
        rd_chk(8'h0c, {12'h000, c0}, 2'b00);
        rd_chk(8'h04, 32'h0, 2'b00);
        chk_bit(1'b0);
        $display("test counting done");
        axi_write(8'h00, 32'h03000005, 2'b00);
        rd_chk(8'h0c, {12'h000, c0}, 2'b00);
        run(192);
        rd_chk(8'h0c, {12'h002, c0}, 2'b00);
        axi_write(8'h00, 32'h01000005, 2'b00);
        chk_bit(1'b0);
        rd_chk(8'h04, 32'h1, 2'b00);
        axi_write(8'h00, 32'h03000005, 2'b00);
        chk_bit(1'b1);
        axi_write(8'h10, 32'h1, 2'b00);
        chk_ev(1'b1);
        rd_chk(8'h14, 32'h1, 2'b00);
        axi_write(8'h14, 32'h1, 2'b00);
        chk_ev(1'b0);
        rd_chk(8'h14, 32'h0, 2'b00);
        $display("test limit_irq done");
        axi_write(8'h00, 32'h02000005, 2'b00);
        axi_read(8'h08, v, r);
        run(288);
        rd_chk(8'h0c, {(c0 == 20'h0) ? 12'h000 : 12'h001, 20'h0}, 2'b00);
        run(160);
        rd_chk(8'h0c, {(c0 == 20'h0) ? 12'h000 : 12'h001, 20'h0}, 2'b00);
        $display("test disable done");
        axi_write(8'h00, 32'h01000000, 2'b00);
        run(160);
        axi_read(8'h08, v, r);
        axi_write(8'h14, 32'h3, 2'b00);
        axi_write(8'h10, 32'h2, 2'b00);
        chk_ev(1'b0);
        run(16 * 4097);
        rd_chk(8'h0c, {12'h001, 20'h0}, 2'b00);
        chk_ev(1'b1);
        $display("test tally_wrap done");
        give_verdict();
    end
endmodule : tkt_tick_timer_test
